// >>> cmpc_defs.vh
`ifndef CMPC_DEFS_VH
`define CMPC_DEFS_VH
// Register offsets (byte addresses, 12-bit decode)
`define CMPC_A_START 12'h000
`define CMPC_A_STOP 12'h004
`define CMPC_A_SAMPLE 12'h008
`define CMPC_A_SUB_START 12'h080
`define CMPC_A_SUB_STOP 12'h084
`define CMPC_A_SUB_SAMPLE 12'h088
`define CMPC_A_EV_READY 12'h100
`define CMPC_A_EV_FALL 12'h104
`define CMPC_A_EV_RISE 12'h108
`define CMPC_A_EV_CROSS 12'h10C
`define CMPC_A_PUB_READY 12'h180
`define CMPC_A_PUB_FALL 12'h184
`define CMPC_A_PUB_RISE 12'h188
`define CMPC_A_PUB_CROSS 12'h18C
`define CMPC_A_LINKS 12'h200
`define CMPC_A_IRQ_MASK 12'h300
`define CMPC_A_IRQ_SET 12'h304
`define CMPC_A_IRQ_CLR 12'h308
`define CMPC_A_OUTCOME 12'h400
`define CMPC_A_ENABLE 12'h500
`define CMPC_A_PSEL 12'h504
`define CMPC_A_REFSRC 12'h508
`define CMPC_A_EXTREF 12'h50C
`define CMPC_A_TH 12'h530
`define CMPC_A_MODE 12'h534
`define CMPC_A_HYST 12'h538
`define CMPC_A_ISRC 12'h53C
// Field positions
`define CMPC_CH_MSB 7
`define CMPC_EN_BIT 31
`define CMPC_TH_LO_MSB 5
`define CMPC_TH_HI_LSB 8
`define CMPC_TH_HI_MSB 13
`define CMPC_MODE_MAIN_BIT 8
`define CMPC_LK_RDY_SAMPLE 0
`define CMPC_LK_RDY_STOP 1
`define CMPC_LK_FALL_STOP 2
`define CMPC_LK_RISE_STOP 3
`define CMPC_LK_CROSS_STOP 4
// Field values and reset values
`define CMPC_ENABLE_ON 2'h2
`define CMPC_REFSRC_EXT 3'h5
`define CMPC_REFSRC_RST 3'h4
// Startup times and clock period in ns
`define CMPC_T_EXTREF_NS 3000
`define CMPC_T_INTREF_NS 50000
`define CMPC_CLK_NS 8
`endif

// >>> cmpc_comparator_control.v
`timescale 1ns/1ns
`include "cmpc_defs.vh"
// Function
// - Above selects lower threshold while running; otherwise upper
// - Thresholds come from their own fields
// - External reference uses selected analog pin
// - Hysteresis register ignored in single-ended mode
// - Ready flag set when comparator is valid
// - Fall, rise and crossing flags on crossings
// - Subscribed channel fires its task
// - Events fire their published channel
// - Ready may trigger sample automatically
// - Ready may trigger stop automatically
// - Crossing events may trigger stop
// - Interrupt enable bits: ready, down, up, cross
// - Set register writes ones into enables
// - Clear register writes ones out of enables
// - Start runs, stop halts, ready after startup
// - Sample captures decision into outcome register
// - Level is field plus one over 64
module cmpc_comparator_control #(
    parameter EXT_START_NS = `CMPC_T_EXTREF_NS,
    parameter INT_START_NS = `CMPC_T_INTREF_NS,
    parameter CHANNELS = 256
) (
    input wire clock,
    input wire srst,
    input wire [11:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [31:0] regRdData,
    input wire compOut,
    input wire [CHANNELS-1:0] channelFire,
    output reg [CHANNELS-1:0] channelEmit,
    output reg coreEnable,
    output reg coreRun,
    output reg [5:0] negativeInputLevel,
    output reg [2:0] referenceSource,
    output reg [2:0] externalReferencePin,
    output reg [2:0] positiveInput,
    output reg [1:0] speedMode,
    output reg differentialMode,
    output reg hysteresisOn,
    output reg [1:0] currentSource,
    output reg irq
);
    // Startup counts, rounded up to whole cycles
    localparam integer EXT_CYC =
        (EXT_START_NS + `CMPC_CLK_NS - 1) / `CMPC_CLK_NS;
    localparam integer INT_CYC =
        (INT_START_NS + `CMPC_CLK_NS - 1) / `CMPC_CLK_NS;
    // Run state machine, one-hot
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_WARM = 3'h2;
    localparam [2:0] ST_RUN = 3'h4;

    reg [31:0] subStart_r, subStop_r, subSample_r; // Channel listen
    reg [31:0] pubReady_r, pubFall_r, pubRise_r, pubCross_r; // Emit
    reg [4:0] links_r; // Event to task links
    reg [3:0] irqEn_r; // Interrupt enables
    reg [3:0] flags_r; // Ready, fall, rise, cross
    reg outcome_r; // Sampled decision
    // Configuration copies for the analog core
    reg [1:0] enable_r;
    reg [2:0] psel_r, refsrc_r, extref_r;
    reg [5:0] thLo_r, thHi_r;
    reg [1:0] speed_r;
    reg mainMode_r;
    reg hyst_r;
    reg [1:0] isrc_r;
    // Sequencer state and warm-up counter
    reg [2:0] state_r;
    reg [15:0] warmCnt_r;
    reg sync1_r, sync2_r, sync3_r; // Pin synchroniser
    reg level_r; // Debounced level
    // Combinational strobes, each valid for one cycle only
    reg [3:0] evPulse; // Events this cycle
    reg doStart, doStop, doSample;
    reg [31:0] rdNxt;
    reg [CHANNELS-1:0] emitNxt;
    integer i;

    // Writes are taken in the strobe cycle; no wait states
    wire wrHit = regWrite;
    wire enabled = (enable_r == `CMPC_ENABLE_ON);
    wire [15:0] warmTarget = (refsrc_r >= `CMPC_REFSRC_RST)
        ? EXT_CYC[15:0] : INT_CYC[15:0];

    // Channel lookup for a subscribe register
    function fires;
        input [31:0] cfg;
        input [CHANNELS-1:0] ch;
        begin
            fires = cfg[`CMPC_EN_BIT] & ch[cfg[`CMPC_CH_MSB:0]];
        end
    endfunction

    // Pin synchroniser: third stage only checks agreement
    always @(posedge clock)
    begin
        if (srst)
        begin
            // All stages and the settled level clear together
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
            level_r <= 1'b0;
        end
        else
        begin
            sync1_r <= compOut;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            // A level toggling every cycle never settles here, so a
            // core left off and wandering cannot fake an edge
            if (sync2_r == sync3_r)
                level_r <= sync3_r;
        end
    end

    // Task sources: register write, channel, links
    always @*
    begin
        doStart = (wrHit && regAddr == `CMPC_A_START && regWrData[0])
            | fires(subStart_r, channelFire);
        // Links never start; start needs software or a channel
        doStop = (wrHit && regAddr == `CMPC_A_STOP && regWrData[0])
            | fires(subStop_r, channelFire)
            | (links_r[`CMPC_LK_RDY_STOP] & evPulse[0])
            | (links_r[`CMPC_LK_FALL_STOP] & evPulse[1])
            | (links_r[`CMPC_LK_RISE_STOP] & evPulse[2])
            | (links_r[`CMPC_LK_CROSS_STOP] & evPulse[3]);
        // Sample from any source; ignored while idle further down
        doSample = (wrHit && regAddr == `CMPC_A_SAMPLE && regWrData[0])
            | fires(subSample_r, channelFire)
            | (links_r[`CMPC_LK_RDY_SAMPLE] & evPulse[0]);
    end

    // Events: ready at end of warm-up, edges while running
    always @*
    begin
        evPulse = 4'h0;
        if (state_r == ST_WARM && warmCnt_r >= warmTarget)
            evPulse[0] = 1'b1;
        // Run entry compares against a cleared copy, so a level
        // already high on entry counts as one upward crossing
        if (state_r == ST_RUN && level_r != coreRun)
        begin
            evPulse[1] = ~level_r;
            evPulse[2] = level_r;
            evPulse[3] = 1'b1;
        end
    end

    // Publish to channels
    always @*
    begin
        // Events sharing one channel simply merge into one pulse
        emitNxt = {CHANNELS{1'b0}};
        for (i = 0; i < 4; i = i + 1)
        begin
            case (i)
                0: if (evPulse[0] && pubReady_r[`CMPC_EN_BIT])
                    emitNxt[pubReady_r[`CMPC_CH_MSB:0]] = 1'b1;
                1: if (evPulse[1] && pubFall_r[`CMPC_EN_BIT])
                    emitNxt[pubFall_r[`CMPC_CH_MSB:0]] = 1'b1;
                2: if (evPulse[2] && pubRise_r[`CMPC_EN_BIT])
                    emitNxt[pubRise_r[`CMPC_CH_MSB:0]] = 1'b1;
                default: if (evPulse[3] && pubCross_r[`CMPC_EN_BIT])
                    emitNxt[pubCross_r[`CMPC_CH_MSB:0]] = 1'b1;
            endcase
        end
    end

    // Read mux; tasks read as zero, unmapped as zero
    always @*
    begin
        case (regAddr)
            // Reads have no side effects, so repeats are harmless
            `CMPC_A_SUB_START: rdNxt = subStart_r;
            `CMPC_A_SUB_STOP: rdNxt = subStop_r;
            `CMPC_A_SUB_SAMPLE: rdNxt = subSample_r;
            `CMPC_A_EV_READY: rdNxt = {31'h0, flags_r[0]};
            `CMPC_A_EV_FALL: rdNxt = {31'h0, flags_r[1]};
            `CMPC_A_EV_RISE: rdNxt = {31'h0, flags_r[2]};
            `CMPC_A_EV_CROSS: rdNxt = {31'h0, flags_r[3]};
            `CMPC_A_PUB_READY: rdNxt = pubReady_r;
            `CMPC_A_PUB_FALL: rdNxt = pubFall_r;
            `CMPC_A_PUB_RISE: rdNxt = pubRise_r;
            `CMPC_A_PUB_CROSS: rdNxt = pubCross_r;
            `CMPC_A_LINKS: rdNxt = {27'h0, links_r};
            `CMPC_A_IRQ_MASK, `CMPC_A_IRQ_SET, `CMPC_A_IRQ_CLR:
                rdNxt = {28'h0, irqEn_r};
            `CMPC_A_OUTCOME: rdNxt = {31'h0, outcome_r};
            `CMPC_A_ENABLE: rdNxt = {30'h0, enable_r};
            `CMPC_A_PSEL: rdNxt = {29'h0, psel_r};
            `CMPC_A_REFSRC: rdNxt = {29'h0, refsrc_r};
            `CMPC_A_EXTREF: rdNxt = {29'h0, extref_r};
            `CMPC_A_TH: rdNxt = {18'h0, thHi_r, 2'h0, thLo_r};
            `CMPC_A_MODE: rdNxt = {23'h0, mainMode_r, 6'h0, speed_r};
            `CMPC_A_HYST: rdNxt = {31'h0, hyst_r};
            `CMPC_A_ISRC: rdNxt = {30'h0, isrc_r};
            default: rdNxt = 32'h0;
        endcase
    end

    // Register file writes and flags
    always @(posedge clock)
    begin
        if (srst)
        begin
            subStart_r <= 32'h0;
            subStop_r <= 32'h0;
            subSample_r <= 32'h0;
            pubReady_r <= 32'h0;
            pubFall_r <= 32'h0;
            pubRise_r <= 32'h0;
            pubCross_r <= 32'h0;
            links_r <= 5'h0;
            irqEn_r <= 4'h0;
            flags_r <= 4'h0;
            outcome_r <= 1'b0;
            enable_r <= 2'h0;
            psel_r <= 3'h0;
            refsrc_r <= `CMPC_REFSRC_RST;
            extref_r <= 3'h0;
            thLo_r <= 6'h0;
            thHi_r <= 6'h0;
            speed_r <= 2'h0;
            mainMode_r <= 1'b0;
            hyst_r <= 1'b0;
            isrc_r <= 2'h0;
            regRdData <= 32'h0;
        end
        else
        begin
            // Read data valid only in the cycle after the strobe
            regRdData <= regRead ? rdNxt : 32'h0;
            if (wrHit)
            begin
                case (regAddr)
                    `CMPC_A_SUB_START: subStart_r <= regWrData;
                    `CMPC_A_SUB_STOP: subStop_r <= regWrData;
                    `CMPC_A_SUB_SAMPLE: subSample_r <= regWrData;
                    `CMPC_A_PUB_READY: pubReady_r <= regWrData;
                    `CMPC_A_PUB_FALL: pubFall_r <= regWrData;
                    `CMPC_A_PUB_RISE: pubRise_r <= regWrData;
                    `CMPC_A_PUB_CROSS: pubCross_r <= regWrData;
                    `CMPC_A_LINKS: links_r <= regWrData[4:0];
                    `CMPC_A_IRQ_MASK: irqEn_r <= regWrData[3:0];
                    `CMPC_A_IRQ_SET:
                        irqEn_r <= irqEn_r | regWrData[3:0];
                    `CMPC_A_IRQ_CLR:
                        irqEn_r <= irqEn_r & ~regWrData[3:0];
                    `CMPC_A_ENABLE: enable_r <= regWrData[1:0];
                    `CMPC_A_PSEL: psel_r <= regWrData[2:0];
                    `CMPC_A_REFSRC: refsrc_r <= regWrData[2:0];
                    `CMPC_A_EXTREF: extref_r <= regWrData[2:0];
                    `CMPC_A_TH:
                    begin
                        thLo_r <= regWrData[`CMPC_TH_LO_MSB:0];
                        thHi_r <= regWrData[`CMPC_TH_HI_MSB:`CMPC_TH_HI_LSB];
                    end
                    `CMPC_A_MODE:
                    begin
                        speed_r <= regWrData[1:0];
                        mainMode_r <= regWrData[`CMPC_MODE_MAIN_BIT];
                    end
                    `CMPC_A_HYST: hyst_r <= regWrData[0];
                    `CMPC_A_ISRC: isrc_r <= regWrData[1:0];
                    default: ;
                endcase
            end
            // Flags: software writes zero, a new event wins
            // Each flag sits one word above the previous one
            for (i = 0; i < 4; i = i + 1)
            begin
                if (evPulse[i])
                    flags_r[i] <= 1'b1;
                else if (wrHit && regAddr == `CMPC_A_EV_READY + 4 * i
                    && !regWrData[0])
                    flags_r[i] <= 1'b0;
            end
            if (doSample && state_r != ST_IDLE)
                outcome_r <= level_r;
        end
    end

    // Run sequencing; stop wins over start in the same cycle
    always @(posedge clock)
    begin
        if (srst)
        begin
            state_r <= ST_IDLE;
            warmCnt_r <= 16'h0;
        end
        else
        begin
            case (state_r)
                // Counter preset so it equals cycles spent warming
                ST_IDLE:
                begin
                    warmCnt_r <= 16'h1;
                    if (doStart && !doStop && enabled)
                        state_r <= ST_WARM;
                end
                ST_WARM:
                begin
                    warmCnt_r <= warmCnt_r + 16'h1;
                    if (doStop || !enabled)
                        state_r <= ST_IDLE;
                    else if (evPulse[0])
                        state_r <= ST_RUN;
                end
                // Stays until stopped or disabled
                ST_RUN:
                    if (doStop || !enabled)
                        state_r <= ST_IDLE;
                // Illegal codes recover to idle
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Registered outputs toward the analog core and fabric
    always @(posedge clock)
    begin
        if (srst)
        begin
            coreEnable <= 1'b0;
            coreRun <= 1'b0;
            negativeInputLevel <= 6'h0;
            referenceSource <= `CMPC_REFSRC_RST;
            externalReferencePin <= 3'h0;
            positiveInput <= 3'h0;
            speedMode <= 2'h0;
            differentialMode <= 1'b0;
            hysteresisOn <= 1'b0;
            currentSource <= 2'h0;
            irq <= 1'b0;
            channelEmit <= {CHANNELS{1'b0}};
        end
        else
        begin
            coreEnable <= enabled;
            // Tracked decision; only follows while running
            // Gated by enable as well, so a careless disable never
            // shows a running decision from a core switched off
            coreRun <= (state_r == ST_RUN && enabled) ? level_r : 1'b0;
            // Ladder code n gives (n+1)/64 of reference
            negativeInputLevel <= ((state_r == ST_RUN) && level_r)
                ? thLo_r : thHi_r;
            referenceSource <= refsrc_r;
            // Pin matters only with external source chosen
            externalReferencePin <= (refsrc_r == `CMPC_REFSRC_EXT)
                ? extref_r : 3'h0;
            positiveInput <= psel_r;
            speedMode <= speed_r;
            differentialMode <= mainMode_r;
            hysteresisOn <= mainMode_r & hyst_r;
            currentSource <= isrc_r;
            // Level output; stays while any enabled flag is set
            irq <= |(flags_r & irqEn_r);
            // One-cycle pulse per published event
            channelEmit <= emitNxt;
        end
    end
endmodule // cmpc_comparator_control

// >>> cmpc_asserts.sv
`timescale 1ns/1ns
module cmpc_asserts (
    input wire clock,
    input wire srst,
    input wire [11:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrite,
    input wire regRead,
    input wire [31:0] regRdData,
    input wire coreEnable,
    input wire coreRun,
    input wire [5:0] negativeInputLevel,
    input wire [2:0] referenceSource,
    input wire [2:0] externalReferencePin,
    input wire differentialMode,
    input wire hysteresisOn,
    input wire irq
);
    // Shadow copies of what software wrote
    logic [5:0] thLo_r;
    logic [3:0] irqEn_r;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    // Follow lower field and interrupt enables as software sees them
    always @(posedge clock)
    begin
        if (srst)
        begin
            thLo_r <= 6'h00;
            irqEn_r <= 4'h0;
        end
        else if (regWrite)
        begin
            case (regAddr)
                12'h530: thLo_r <= regWrData[5:0];
                12'h300: irqEn_r <= regWrData[3:0];
                12'h304: irqEn_r <= irqEn_r | regWrData[3:0];
                12'h308: irqEn_r <= irqEn_r & ~regWrData[3:0];
                default: ;
            endcase
        end
    end
    property p_lower;
        $rose(coreRun) |-> ##[0:1] negativeInputLevel == thLo_r;
    endproperty
    a_lower: assert property (p_lower) else $error("lower");
    property p_ext;
        referenceSource != 3'h5 |-> externalReferencePin == 3'h0;
    endproperty
    a_ext: assert property (p_ext) else $error("extpin");
    property p_hyst;
        hysteresisOn |-> differentialMode;
    endproperty
    a_hyst: assert property (p_hyst) else $error("hyst");
    property p_en;
        regWrite && regAddr == 12'h500 && regWrData == 32'h2
            |-> ##2 coreEnable;
    endproperty
    a_en: assert property (p_en) else $error("enable");
    property p_run;
        !coreEnable |-> !coreRun;
    endproperty
    a_run: assert property (p_run) else $error("run");
    property p_irq;
        irqEn_r == 4'h0 && $past(irqEn_r) == 4'h0 |=> !irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_task;
        $past(regRead) && $past(regAddr) <= 12'h008 |-> regRdData == 32'h0;
    endproperty
    a_task: assert property (p_task) else $error("task");
    property p_set;
        $past(regRead) && $past(regAddr) == 12'h304
            |-> regRdData[3:0] == $past(irqEn_r);
    endproperty
    a_set: assert property (p_set) else $error("setread");
endmodule // cmpc_asserts

// >>> cmpc_core_model.sv
`timescale 1ns/1ns
module cmpc_core_model (
    input wire clock,
    input wire coreEnable,
    input wire [5:0] negativeInputLevel,
    input wire [6:0] vinCode,
    output wire compOut
);
    // Output of a core that is off means nothing, so it wanders
    logic wander_r = 1'b0;
    always @(posedge clock)
    begin
        wander_r <= ~wander_r;
    end
    // Level is (code+1)/64 of reference; async, lands mid-cycle
    assign #3 compOut = coreEnable ?
        (vinCode > {1'b0, negativeInputLevel} + 7'h01) : wander_r;
endmodule // cmpc_core_model

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [11:0] regAddr = 12'h000;
    logic [31:0] regWrData = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [255:0] channelFire = 256'h0;
    logic [6:0] vinCode = 7'h14;
    wire [31:0] regRdData;
    wire [255:0] channelEmit;
    wire compOut, coreEnable, coreRun, irq, hysteresisOn;
    wire [5:0] negativeInputLevel;
    wire [2:0] referenceSource;
    wire [2:0] externalReferencePin;
    wire [2:0] positiveInput;
    wire [1:0] speedMode, currentSource;
    wire differentialMode;
    int errorCnt = 0;
    int checksDone = 0;
    int cycleCnt = 0;
    int warmN = 0;
    logic rdPend = 1'b0;
    logic [31:0] expQ[$];
    logic [31:0] rnd = 32'h104CCD4C;
    logic [7:0] pubCh = 8'h00;
    // Short start-up so ready comes after ten cycles, or twenty with reference source below 4
    cmpc_comparator_control #(.EXT_START_NS(80), .INT_START_NS(160))
        cmpc_comparator_control_inst (.clock(clock), .srst(srst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .compOut(compOut),
        .channelFire(channelFire), .channelEmit(channelEmit),
        .coreEnable(coreEnable), .coreRun(coreRun),
        .negativeInputLevel(negativeInputLevel),
        .referenceSource(referenceSource),
        .externalReferencePin(externalReferencePin),
        .positiveInput(positiveInput), .speedMode(speedMode),
        .differentialMode(differentialMode),
        .hysteresisOn(hysteresisOn), .currentSource(currentSource),
        .irq(irq));
    cmpc_core_model cmpc_core_model_inst (.clock(clock),
        .coreEnable(coreEnable), .negativeInputLevel(negativeInputLevel),
        .vinCode(vinCode), .compOut(compOut));
    always #4 clock = ~clock;
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checksDone++;
        if (g !== e)
        begin
            errorCnt++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task end_sim;
        if (errorCnt == 0 && checksDone > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One-cycle write strobe
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    // Read strobe; the expected word waits in the queue
    task rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        expQ.push_back(e);
        @(posedge clock);
        regRead <= 1'b0;
    endtask
    // Bounded wait on ready emit (sel) or tracked decision
    task waitUntil(input bit sel, input logic v);
        int n;
        n = 0;
        while ((sel ? channelEmit[pubCh] : coreRun) !== v && n < 200)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n == 200)
            chk("wait", 32'h1, 32'h0);
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge clock)
    begin
        rdPend <= regRead;
        cycleCnt++;
        if (cycleCnt == 5000)
        begin
            errorCnt++;
            end_sim;
        end
    end
    always @(negedge clock)
    begin
        if (rdPend)
            chk("regRdData", expQ.pop_front(), regRdData);
    end
    initial
    begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        rd(12'h300, 32'h0);
        rd(12'h200, 32'h0);
        rd(12'h100, 32'h0);
        chk("refSrc", 32'h4, {29'h0, referenceSource});
        rnd = lfsr(rnd);
        pubCh = rnd[7:0];
        wr(12'h180, {24'h800000, pubCh});
        wr(12'h504, 32'h6);
        wr(12'h53C, 32'h1);
        wr(12'h530, 32'h280A);
        wr(12'h508, 32'h5);
        wr(12'h50C, 32'h3);
        wr(12'h538, rnd);
        wr(12'h534, 32'h2);
        chk("extPin", 32'h3, {29'h0, externalReferencePin});
        chk("hyst", 32'h0, {31'h0, hysteresisOn});
        wr(12'h304, 32'hF);
        rd(12'h300, 32'hF);
        chk("psel", 32'h6, {29'h0, positiveInput});
        chk("speed", 32'h2, {30'h0, speedMode});
        chk("isrc", 32'h1, {30'h0, currentSource});
        chk("diff", 32'h0, {31'h0, differentialMode});
        wr(12'h308, 32'h5);
        rd(12'h304, 32'hA);
        wr(12'h300, 32'h1);
        rd(12'h308, 32'h1);
        wr(12'h200, 32'h1);
        wr(12'h500, 32'h2);
        chk("lvl", 32'h28, {26'h0, negativeInputLevel});
        vinCode <= 7'h32;
        wr(12'h000, 32'h1);
        waitUntil(1'b1, 1'b1);
        rd(12'h100, 32'h1);
        rd(12'h400, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        for (int i = 0; i < 4; i++)
            wr(12'h100 + 12'(4 * i), 32'h0);
        rd(12'h100, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        chk("lvl", 32'hA, {26'h0, negativeInputLevel});
        vinCode <= 7'h14;
        repeat (8) @(posedge clock);
        chk("run", 32'h1, {31'h0, coreRun});
        vinCode <= 7'h05;
        waitUntil(1'b0, 1'b0);
        rd(12'h104, 32'h1);
        rd(12'h108, 32'h0);
        rd(12'h10C, 32'h1);
        chk("lvl", 32'h28, {26'h0, negativeInputLevel});
        vinCode <= 7'h32;
        waitUntil(1'b0, 1'b1);
        rd(12'h108, 32'h1);
        wr(12'h088, 32'h80000009);
        vinCode <= 7'h05;
        waitUntil(1'b0, 1'b0);
        @(posedge clock);
        channelFire[9] <= 1'b1;
        @(posedge clock);
        channelFire[9] <= 1'b0;
        rd(12'h400, 32'h0);
        rd(12'h008, 32'h0);
        wr(12'h200, 32'h10);
        vinCode <= 7'h32;
        waitUntil(1'b0, 1'b1);
        repeat (4) @(posedge clock);
        chk("run", 32'h0, {31'h0, coreRun});
        vinCode <= 7'h05;
        wr(12'h104, 32'h0);
        repeat (16) @(posedge clock);
        rd(12'h104, 32'h0);
        wr(12'h108, 32'h0);
        wr(12'h508, 32'h1);
        wr(12'h000, 32'h1);
        while (channelEmit[pubCh] !== 1'b1 && warmN < 100)
        begin
            @(posedge clock);
            #1;
            warmN++;
        end
        chk("warm", 32'h14, warmN);
        wr(12'h004, 32'h1);
        vinCode <= 7'h32;
        repeat (12) @(posedge clock);
        rd(12'h108, 32'h0);
        wr(12'h500, 32'h0);
        repeat (2) @(posedge clock);
        chk("en", 32'h0, {31'h0, coreEnable});
        wr(12'h534, 32'h100);
        wr(12'h538, 32'h1);
        repeat (2) @(posedge clock);
        chk("hyst", 32'h1, {31'h0, hysteresisOn});
        chk("diff", 32'h1, {31'h0, differentialMode});
        end_sim;
    end
endmodule // tb_top
bind cmpc_comparator_control cmpc_asserts cmpc_asserts_inst (
    .clock(clock), .srst(srst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .coreEnable(coreEnable), .coreRun(coreRun),
    .negativeInputLevel(negativeInputLevel),
    .referenceSource(referenceSource),
    .externalReferencePin(externalReferencePin),
    .differentialMode(differentialMode),
    .hysteresisOn(hysteresisOn), .irq(irq));
